// >>> logic/gpi_map.svh
`ifndef GPI_MAP_SVH
`define GPI_MAP_SVH
// Port registers, port 1 one word above port 0
`define GPI_DIR0 8'h00
`define GPI_DIR1 8'h04
`define GPI_MSK0 8'h08
`define GPI_MSK1 8'h0c
`define GPI_PIN0 8'h10
`define GPI_PIN1 8'h14
`define GPI_MPN0 8'h18
`define GPI_MPN1 8'h1c
`define GPI_SET0 8'h20
`define GPI_SET1 8'h24
`define GPI_CLR0 8'h28
`define GPI_CLR1 8'h2c
`define GPI_NOT0 8'h30
`define GPI_NOT1 8'h34
`define GPI_OUT0 8'h38
`define GPI_OUT1 8'h3c
// Pin interrupt and pattern registers
`define GPI_PSL0 8'h40
`define GPI_PSL1 8'h44
`define GPI_IMOD 8'h48
`define GPI_IENR 8'h4c
`define GPI_IENF 8'h50
`define GPI_IST 8'h54
`define GPI_PMCT 8'h58
`define GPI_PMSR 8'h5c
`define GPI_PMCD 8'h60
// Group registers
`define GPI_G0CT 8'h64
`define GPI_G1CT 8'h68
`define GPI_G0E0 8'h70
`define GPI_G0E1 8'h74
`define GPI_G1E0 8'h78
`define GPI_G1E1 8'h7c
`define GPI_G0P0 8'h80
`define GPI_G0P1 8'h84
`define GPI_G1P0 8'h88
`define GPI_G1P1 8'h8c
// Power modes
`define GPI_PM_ACT 2'h0
`define GPI_PM_SLP 2'h1
`define GPI_PM_DSL 2'h2
`define GPI_PM_PDN 2'h3
// Slice conditions
`define GPI_CD_ONE 3'h0
`define GPI_CD_STR 3'h1
`define GPI_CD_STF 3'h2
`define GPI_CD_STE 3'h3
`define GPI_CD_HI 3'h4
`define GPI_CD_LO 3'h5
`define GPI_CD_ZERO 3'h6
`define GPI_CD_EVT 3'h7
// Reset values
`define GPI_RST_OE_N 64'hffff_ffff_ffff_ffff
`endif

// >>> logic/gpi_pkg.sv
package gpi_pkg;
  typedef struct packed {
    logic [63:0] s1;
    logic [63:0] s2;
  } gpi_sync_s;
  typedef struct packed {
    logic [7:0] prv;
    logic [7:0] pend;
    logic [7:0] irq;
  } gpi_pint_s;
  typedef struct packed {
    logic [1:0][31:0] dir;
    logic [1:0][31:0] msk;
    logic [1:0][31:0] out;
    logic [63:0] pout;
    logic [63:0] poe_n;
    logic [63:0] pprv;
    logic [1:0][3:0][5:0] chsel;
    logic [7:0] imod;
    logic [7:0] ienr;
    logic [7:0] ienf;
    logic pmen;
    logic pmev;
    logic pmrt;
    logic [5:0] pmpin;
    logic [7:0][2:0] pmsrc;
    logic [7:0][2:0] pmcd;
    logic [7:0] pmend;
    logic [7:0] stky;
    logic [7:0] pmirq;
    logic pmany;
    logic cev;
    logic wake;
    logic [1:0] gcmb;
    logic [1:0] gcnd;
    logic [1:0] gpnd;
    logic [1:0][1:0][31:0] gena;
    logic [1:0][1:0][31:0] gpol;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gpi_st_s;
endpackage

// >>> logic/gpi_pint_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gpi_pint_if;
  logic [7:0] lvl;
  logic [7:0] imod;
  logic [7:0] ienr;
  logic [7:0] ienf;
  logic [7:0] clr;
  logic [7:0] pend;
  logic [7:0] irq;
  modport ctl (output lvl, imod, ienr, ienf, clr, input pend, irq);
  modport unit (input lvl, imod, ienr, ienf, clr, output pend, irq);
endinterface
`default_nettype wire

// >>> logic/gpi_sync.sv
`timescale 1ns/1ns
`default_nettype none
module gpi_sync
  import gpi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [63:0] d,
  output logic [63:0] q
);
  gpi_sync_s st;
  gpi_sync_s nx;

  // Two stages, second alone reads the first
  always_comb begin
    nx = st;
    nx.s1 = d;
    nx.s2 = st.s1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign q = st.s2;

  property p_sync;
    @(posedge mclk) disable iff (rst)
      !$past(rst) && !$past(rst, 2) |-> q == $past(d, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync delay wrong");
endmodule
`default_nettype wire

// >>> logic/gpi_pint.sv
`timescale 1ns/1ns
`default_nettype none
module gpi_pint
  import gpi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  gpi_pint_if.unit pi
);
  gpi_pint_s st;
  gpi_pint_s nx;
  logic [7:0] eset;
  logic [7:0] lvact;
  logic [7:0] keep;

  // Qualifying edges and active levels
  assign eset = ~pi.imod & ((pi.ienr & pi.lvl & ~st.prv)
    | (pi.ienf & ~pi.lvl & st.prv));
  assign lvact = pi.imod & pi.ienr & ~(pi.lvl ^ pi.ienf);
  assign keep = st.pend & ~pi.clr;

  // Pending flags, a new edge beats a clear
  always_comb begin
    nx = st;
    nx.prv = pi.lvl;
    nx.pend = eset | keep;
    nx.irq = (nx.pend & ~pi.imod) | lvact;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign pi.pend = st.pend;
  assign pi.irq = st.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_edge;
    eset != 8'h0 |=> (pi.irq & $past(eset)) == $past(eset);
  endproperty
  a_edge: assert property (p_edge) else $error("edge lost");
  property p_keep;
    keep != 8'h0 |=> (pi.pend & $past(keep)) == $past(keep);
  endproperty
  a_keep: assert property (p_keep) else $error("pending dropped");
  property p_lvl;
    lvact != 8'h0 |=> (pi.irq & $past(lvact)) == $past(lvact);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level irq missing");
endmodule
`default_nettype wire

// >>> logic/gpi_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpi_map.svh"
module gpi_top
  import gpi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] pwr_mode,
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe_n,
  output logic [7:0] pint_irq,
  output logic [7:0] pmatch_irq,
  output logic [1:0] grp_irq,
  output logic cpu_event_notify,
  output logic wake_req
);
  gpi_st_s st;
  gpi_st_s nx;
  gpi_pint_if pi ();
  logic [63:0] pin_s;
  logic [1:0][31:0] pin_rd;
  logic [31:0] lm;
  logic [31:0] rd;
  logic [31:0] wv;
  logic [31:0] wm;
  logic hit;
  logic hold;
  logic wr;
  logic p;
  logic stclr;
  logic [1:0] gclr;
  logic [7:0] pm_in;
  logic [7:0] pm_pv;
  logic [7:0] s_h;
  logic [7:0] s_e;
  logic [7:0] s_run;
  logic [7:0] brk;
  logic [7:0] runp;
  logic [7:0] mt;
  logic [63:0] rt;
  logic [63:0] gt;
  logic gc;

  // Pin synchroniser
  gpi_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(pin_in),
    .q(pin_s)
  );

  // Pin interrupt unit, eight channels
  gpi_pint u_pint (
    .mclk(mclk),
    .rst(rst),
    .pi(pi)
  );

  // Bus qualifiers and lane masks
  assign lm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign p = paddr[2];
  assign hold = (pwr_mode == `GPI_PM_DSL) || (pwr_mode == `GPI_PM_PDN);
  assign wr = psel && penable && st.pready && pwrite && hit
    && !hold;
  assign wv = (rd & ~lm) | (pwdata & lm);
  assign wm = pwdata & lm;
  assign stclr = wr && ((paddr == `GPI_PMCT) || (paddr == `GPI_PMSR)
    || (paddr == `GPI_PMCD));
  assign gclr[0] = wr && (paddr == `GPI_G0CT) && wm[0];
  assign gclr[1] = wr && (paddr == `GPI_G1CT) && wm[0];

  // Readback zero in power-down
  assign pin_rd = (pwr_mode == `GPI_PM_PDN) ? 64'h0 : pin_s;

  // Pin interrupt unit configuration
  assign pi.lvl = pm_in;
  assign pi.imod = st.imod;
  assign pi.ienr = st.ienr;
  assign pi.ienf = st.ienf;
  assign pi.clr = (wr && paddr == `GPI_IST) ? wm[7:0] : 8'h0;

  // Product-term chaining
  assign brk = {st.pmend[6:0], 1'b1};
  assign runp = {s_run[6:0], 1'b0};
  assign mt = s_run & st.pmend & {8{st.pmen}};

  // Per-slice pin pick and condition
  for (genvar s = 0; s < 8; s++) begin : g_slice
    logic si;
    logic sp;
    logic sr;
    logic sf;
    logic h;
    logic e;
    assign pm_in[s] = pin_s[st.chsel[s/4][s%4]];
    assign pm_pv[s] = st.pprv[st.chsel[s/4][s%4]];
    assign si = pm_in[st.pmsrc[s]];
    assign sp = pm_pv[st.pmsrc[s]];
    assign sr = si & ~sp;
    assign sf = sp & ~si;
    // Condition selected for this slice
    always_comb begin
      e = 1'b0;
      h = 1'b0;
      unique case (st.pmcd[s])
        `GPI_CD_ONE: h = 1'b1;
        `GPI_CD_STR: begin
          e = sr;
          h = st.stky[s] | sr;
        end
        `GPI_CD_STF: begin
          e = sf;
          h = st.stky[s] | sf;
        end
        `GPI_CD_STE: begin
          e = sr | sf;
          h = st.stky[s] | sr | sf;
        end
        `GPI_CD_HI: h = si;
        `GPI_CD_LO: h = ~si;
        `GPI_CD_ZERO: h = 1'b0;
        `GPI_CD_EVT: h = sr | sf;
      endcase
    end
    assign s_h[s] = h;
    assign s_e[s] = e;
    assign s_run[s] = h & (brk[s] | runp[s]);
  end

  // Register read decode
  always_comb begin
    hit = 1'b1;
    rd = 32'h0;
    case (paddr)
      `GPI_DIR0, `GPI_DIR1: rd = st.dir[p];
      `GPI_MSK0, `GPI_MSK1: rd = st.msk[p];
      `GPI_PIN0, `GPI_PIN1: rd = pin_rd[p];
      `GPI_MPN0, `GPI_MPN1: rd = pin_rd[p] & ~st.msk[p];
      `GPI_SET0, `GPI_SET1: rd = st.out[p];
      `GPI_CLR0, `GPI_CLR1: rd = st.out[p];
      `GPI_NOT0, `GPI_NOT1: rd = st.out[p];
      `GPI_OUT0, `GPI_OUT1: rd = st.out[p];
      `GPI_PSL0, `GPI_PSL1: rd = {2'h0, st.chsel[p][3], 2'h0,
        st.chsel[p][2], 2'h0, st.chsel[p][1], 2'h0, st.chsel[p][0]};
      `GPI_IMOD: rd = {24'h0, st.imod};
      `GPI_IENR: rd = {24'h0, st.ienr};
      `GPI_IENF: rd = {24'h0, st.ienf};
      `GPI_IST: rd = {24'h0, pi.irq};
      `GPI_PMCT: rd = {st.pmirq, 10'h0, st.pmpin, 5'h0, st.pmrt,
        st.pmev, st.pmen};
      `GPI_PMSR: rd = {8'h0, st.pmsrc};
      `GPI_PMCD: rd = {st.pmend, st.pmcd};
      `GPI_G0CT: rd = {29'h0, st.gcnd[0], st.gcmb[0], st.gpnd[0]};
      `GPI_G1CT: rd = {29'h0, st.gcnd[1], st.gcmb[1], st.gpnd[1]};
      `GPI_G0E0, `GPI_G0E1: rd = st.gena[0][p];
      `GPI_G1E0, `GPI_G1E1: rd = st.gena[1][p];
      `GPI_G0P0, `GPI_G0P1: rd = st.gpol[0][p];
      `GPI_G1P0, `GPI_G1P1: rd = st.gpol[1][p];
      default: hit = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    nx = st;
    rt = 64'h0;
    gt = 64'h0;
    gc = 1'b0;
    // Answer in the first access cycle
    nx.pready = psel & ~penable;
    nx.pslverr = psel & ~penable & ~hit;
    if (psel && !penable) begin
      nx.prdata = rd;
    end
    // Register writes
    if (wr) begin
      case (paddr)
        `GPI_DIR0, `GPI_DIR1: nx.dir[p] = wv;
        `GPI_MSK0, `GPI_MSK1: nx.msk[p] = wv;
        `GPI_PIN0, `GPI_PIN1: nx.out[p] = (st.out[p] & ~lm) | wm;
        `GPI_MPN0, `GPI_MPN1: nx.out[p] = (st.out[p]
          & ~(lm & ~st.msk[p])) | (wm & ~st.msk[p]);
        `GPI_SET0, `GPI_SET1: nx.out[p] = st.out[p] | wm;
        `GPI_CLR0, `GPI_CLR1: nx.out[p] = st.out[p] & ~wm;
        `GPI_NOT0, `GPI_NOT1: nx.out[p] = st.out[p] ^ wm;
        `GPI_OUT0, `GPI_OUT1: nx.out[p] = wv;
        `GPI_PSL0, `GPI_PSL1: begin
          for (int i = 0; i < 4; i++) begin
            nx.chsel[p][i] = wv[8*i +: 6];
          end
        end
        `GPI_IMOD: nx.imod = wv[7:0];
        `GPI_IENR: nx.ienr = wv[7:0];
        `GPI_IENF: nx.ienf = wv[7:0];
        `GPI_PMCT: begin
          nx.pmen = wv[0];
          nx.pmev = wv[1];
          nx.pmrt = wv[2];
          nx.pmpin = wv[13:8];
        end
        `GPI_PMSR: nx.pmsrc = wv[23:0];
        `GPI_PMCD: {nx.pmend, nx.pmcd} = wv;
        `GPI_G0CT: nx.gcmb[0] = wv[1];
        `GPI_G1CT: nx.gcmb[1] = wv[1];
        `GPI_G0E0, `GPI_G0E1: nx.gena[0][p] = wv;
        `GPI_G1E0, `GPI_G1E1: nx.gena[1][p] = wv;
        `GPI_G0P0, `GPI_G0P1: nx.gpol[0][p] = wv;
        `GPI_G1P0, `GPI_G1P1: nx.gpol[1][p] = wv;
        default: ;
      endcase
    end
    // Pattern terms, sticky edges and event pulse
    nx.pprv = pin_s;
    nx.stky = s_e | (st.stky & ~{8{stclr}});
    nx.pmirq = mt;
    nx.pmany = |mt;
    nx.cev = st.pmev & (|mt) & ~st.pmany;
    // Pin drivers, event routing and power-down
    if (st.pmrt) begin
      rt = 64'h1 << st.pmpin;
    end
    nx.pout = (st.out & ~rt) | (rt & {64{st.cev}});
    nx.poe_n = ~st.dir & ~rt;
    if (pwr_mode == `GPI_PM_PDN) begin
      nx.pout = 64'h0;
    end
    // Group interrupts, rise of the condition beats a clear
    for (int g = 0; g < 2; g++) begin
      gt = ~(pin_s ^ st.gpol[g]) & st.gena[g];
      gc = st.gcmb[g] ? ((st.gena[g] != 64'h0) && (gt == st.gena[g]))
        : (gt != 64'h0);
      nx.gcnd[g] = gc;
      nx.gpnd[g] = (gc & ~st.gcnd[g])
        | (st.gpnd[g] & ~gclr[g]);
    end
    // Wake request by power mode
    nx.wake = ((|st.gpnd) && pwr_mode != `GPI_PM_ACT)
      || ((|pi.irq) && (pwr_mode == `GPI_PM_SLP
      || pwr_mode == `GPI_PM_DSL))
      || ((|st.pmirq) && (pwr_mode == `GPI_PM_ACT
      || pwr_mode == `GPI_PM_SLP));
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.poe_n <= `GPI_RST_OE_N;
    end else begin
      st <= nx;
    end
  end

  // Outputs from flip-flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pin_out = st.pout;
  assign pin_oe_n = st.poe_n;
  assign pint_irq = pi.irq;
  assign pmatch_irq = st.pmirq;
  assign grp_irq = st.gpnd;
  assign cpu_event_notify = st.cev;
  assign wake_req = st.wake;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic wfull;
  logic [31:0] tog0;
  logic [31:0] pin_lo;
  assign wfull = wr && (pstrb == 4'hf);
  assign tog0 = st.out[0] ^ pwdata;
  assign pin_lo = pin_s[31:0];

  property p_rst;
    $fell(rst) |-> (pin_oe_n == `GPI_RST_OE_N) && (st.dir == 64'h0);
  endproperty
  a_rst: assert property (p_rst) else $error("pins not input");
  property p_set;
    wfull && paddr == `GPI_SET0
      |=> (st.out[0] & $past(pwdata)) == $past(pwdata);
  endproperty
  a_set: assert property (p_set) else $error("set failed");
  property p_tog;
    wfull && paddr == `GPI_NOT0 |=> st.out[0] == $past(tog0);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle failed");
  property p_lane;
    wr && paddr == `GPI_DIR0 && pstrb == 4'h1
      |=> $stable(st.dir[0][31:8]);
  endproperty
  a_lane: assert property (p_lane) else $error("lane leak");
  property p_pdn;
    (pwr_mode == `GPI_PM_PDN) [*2] |-> pin_out == 64'h0;
  endproperty
  a_pdn: assert property (p_pdn) else $error("pin not low");
  property p_hold;
    hold |=> $stable(st.dir) && $stable(st.out) && $stable(st.msk);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved");
  sequence s_pulse;
    cpu_event_notify ##1 !cpu_event_notify;
  endsequence
  property p_cev;
    (|mt) && !st.pmany && st.pmev |=> s_pulse;
  endproperty
  a_cev: assert property (p_cev) else $error("event pulse bad");
  property p_grp;
    $rose(st.gcnd[0]) |-> grp_irq[0];
  endproperty
  a_grp: assert property (p_grp) else $error("group missed");
  property p_pmw;
    pwr_mode == `GPI_PM_DSL && grp_irq == 2'h0 && pint_irq == 8'h0
      |=> !wake_req;
  endproperty
  a_pmw: assert property (p_pmw) else $error("bad pattern wake");
  property p_pin;
    psel && !penable && paddr == `GPI_PIN0 && pwr_mode != `GPI_PM_PDN
      |=> prdata == $past(pin_lo);
  endproperty
  a_pin: assert property (p_pin) else $error("pin read bad");
  property p_ans;
    psel && !penable |=> pready;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
endmodule
`default_nettype wire

// >>> test/gpi_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// Outside world on the pins: a driven pin shows the device level
module gpi_pins_model (
  input wire logic mclk,
  input wire logic lag,
  input wire logic [63:0] ext,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe_n,
  output logic [63:0] pin_in
);
  logic [63:0] ext_d;
  // Slow sources settle one clock late
  always_ff @(posedge mclk) begin
    ext_d <= ext;
  end
  // Wire level, device wins while its enable is low
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      pin_in[i] = pin_oe_n[i] ? (lag ? ext_d[i] : ext[i]) : pin_out[i];
    end
  end
endmodule
`default_nettype wire

// >>> test/gpio_pin_interrupt_pattern_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpi_map.svh"
module gpio_pin_interrupt_pattern_test
  import gpi_pkg::*;
;
  logic mclk, rst, psel, penable, pwrite, lag, pready, pslverr, err;
  logic cpu_event_notify, wake_req;
  logic [7:0] paddr, pint_irq, pmatch_irq;
  logic [31:0] pwdata, prdata, rd, d, msk;
  logic [3:0] pstrb, s;
  logic [1:0] pwr_mode, grp_irq;
  logic [63:0] ext, pin_in, pin_out, pin_oe_n;
  logic [31:0] out_m [2];
  logic [31:0] dir_m [2];
  int n_fail, n_checks, k, j;
  integer seed;

  gpi_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwr_mode(pwr_mode), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pint_irq(pint_irq), .pmatch_irq(pmatch_irq),
    .grp_irq(grp_irq), .cpu_event_notify(cpu_event_notify),
    .wake_req(wake_req));
  gpi_pins_model pins (.mclk(mclk), .lag(lag), .ext(ext),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

  // Clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dd, input logic [3:0] st);
    int t;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20 && pready !== 1'b1) begin
      n_fail++;
      conclude();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    apb(1'b1, a, dd, 4'hf);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hf);
    chk({32'h0, e}, {32'h0, rd});
  endtask
  // Byte lanes selected by a strobe
  function automatic logic [31:0] lanes(input logic [3:0] st);
    return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction
  // Expected wire levels of one port
  function automatic logic [31:0] pins_exp(input int p);
    return (dir_m[p] & out_m[p]) | (~dir_m[p] & ext[32*p +: 32]);
  endfunction

  // Hang guard
  initial begin
    cyc(20000);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 32'h8b66;
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pwr_mode = `GPI_PM_ACT;
    ext = 64'h0;
    lag = 1'b0;
    cyc(2);
    rst <= 1'b0;
    #1 chk(64'hffff_ffff_ffff_ffff, pin_oe_n);
    rdc(`GPI_DIR0, 32'h0);
    rdc(`GPI_DIR1, 32'h0);
    $display("reset test done");
    // Port writes, lanes and readback
    lag <= 1'b1;
    ext <= {32'($random(seed)), 32'($random(seed)) & 32'hffff_ff00};
    for (int p = 0; p < 2; p++) begin
      dir_m[p] = 32'($random(seed)) & (p == 0 ? 32'hffff_ff00 : 32'hffff_ffff);
      wr(`GPI_DIR0 + 8'(4 * p), dir_m[p]);
      out_m[p] = $random(seed);
      wr(`GPI_OUT0 + 8'(4 * p), out_m[p]);
      d = $random(seed);
      wr(`GPI_SET0 + 8'(4 * p), d);
      out_m[p] = out_m[p] | d;
      d = $random(seed);
      wr(`GPI_CLR0 + 8'(4 * p), d);
      out_m[p] = out_m[p] & ~d;
      d = $random(seed);
      wr(`GPI_NOT0 + 8'(4 * p), d);
      out_m[p] = out_m[p] ^ d;
      d = $random(seed);
      s = 4'($random(seed)) | 4'h2;
      apb(1'b1, `GPI_OUT0 + 8'(4 * p), d, s);
      out_m[p] = (out_m[p] & ~lanes(s)) | (d & lanes(s));
      rdc(`GPI_OUT0 + 8'(4 * p), out_m[p]);
      rdc(`GPI_DIR0 + 8'(4 * p), dir_m[p]);
      cyc(6);
      rdc(`GPI_PIN0 + 8'(4 * p), pins_exp(p));
    end
    #1 chk(~{dir_m[1], dir_m[0]}, pin_oe_n);
    chk({dir_m[1], dir_m[0]} & {out_m[1], out_m[0]},
        {dir_m[1], dir_m[0]} & pin_out);
    // Low lane only, upper lanes carry inverted data that must not land
    apb(1'b1, `GPI_DIR0, {~dir_m[0][31:8], 8'h00}, 4'h1);
    rdc(`GPI_DIR0, dir_m[0]);
    msk = $random(seed);
    wr(`GPI_MSK0, msk);
    d = $random(seed);
    wr(`GPI_MPN0, d);
    out_m[0] = (out_m[0] & msk) | (d & ~msk);
    cyc(6);
    rdc(`GPI_MPN0, pins_exp(0) & ~msk);
    rdc(`GPI_OUT0, out_m[0]);
    apb(1'b0, 8'h6c, 32'h0, 4'hf);
    chk(64'h1, {63'h0, err});
    apb(1'b1, 8'hfc, 32'h0, 4'hf);
    chk(64'h1, {63'h0, err});
    $display("port test done");
    // Low power modes
    pwr_mode <= `GPI_PM_DSL;
    wr(`GPI_OUT0, ~out_m[0]);
    rdc(`GPI_OUT0, out_m[0]);
    pwr_mode <= `GPI_PM_PDN;
    cyc(2);
    #1 chk(64'h0, pin_out);
    rdc(`GPI_PIN1, 32'h0);
    pwr_mode <= `GPI_PM_ACT;
    cyc(2);
    #1 chk({dir_m[1], dir_m[0]} & {out_m[1], out_m[0]},
           {dir_m[1], dir_m[0]} & pin_out);
    $display("power test done");
    // Edge channels: rising, falling, both
    lag <= 1'b0;
    ext[3] <= 1'b0;
    wr(`GPI_PSL0, 32'h0000_0003);
    wr(`GPI_IMOD, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(`GPI_IENR, {31'h0, m != 1});
      wr(`GPI_IENF, {31'h0, m != 0});
      wr(`GPI_IST, 32'hff);
      cyc(2);
      ext[3] <= 1'b1;
      cyc(8);
      #1 chk({63'h0, m != 1}, {63'h0, pint_irq[0]});
      wr(`GPI_IST, 32'h1);
      cyc(2);
      #1 chk(64'h0, {63'h0, pint_irq[0]});
      ext[3] <= 1'b0;
      cyc(8);
      #1 chk({63'h0, m != 0}, {56'h0, pint_irq});
      wr(`GPI_IST, 32'h1);
    end
    // Level channels, both polarities
    wr(`GPI_IMOD, 32'h1);
    wr(`GPI_IENR, 32'h1);
    pwr_mode <= `GPI_PM_SLP;
    for (int p = 0; p < 2; p++) begin
      wr(`GPI_IENF, 32'(p));
      ext[3] <= p[0];
      cyc(6);
      #1 chk(64'h1, {63'h0, pint_irq[0]});
      chk(64'h1, {63'h0, wake_req});
      ext[3] <= ~p[0];
      cyc(6);
      #1 chk(64'h0, {63'h0, pint_irq[0]});
    end
    pwr_mode <= `GPI_PM_ACT;
    wr(`GPI_IMOD, 32'h0);
    wr(`GPI_IENR, 32'h0);
    $display("pin interrupt test done");
    // Pattern: slice 0 high on channel 0 pin, one term
    wr(`GPI_PMSR, 32'h0);
    wr(`GPI_PMCD, 32'h0100_0004);
    // Event enabled and routed to pin 9
    wr(`GPI_PMCT, 32'h0000_0907);
    cyc(2);
    ext[3] <= 1'b1;
    k = 0;
    j = 0;
    repeat (10) begin
      @(posedge mclk);
      #1;
      if (cpu_event_notify === 1'b1) k++;
      if (pin_out[9] === 1'b1) j++;
    end
    chk(64'h01, {56'h0, pmatch_irq});
    chk(64'h1, 64'(k));
    chk(64'h1, 64'(j));
    chk(64'h0, {63'h0, pin_oe_n[9]});
    chk(64'h1, {63'h0, wake_req});
    ext[3] <= 1'b0;
    cyc(4);
    #1 chk(64'h0, {56'h0, pmatch_irq});
    wr(`GPI_PMCT, 32'h0);
    $display("pattern test done");
    // Groups: OR on pin 5, AND of pin 6 high and pin 7 low
    wr(`GPI_G0E0, 32'h20);
    wr(`GPI_G0P0, 32'h20);
    wr(`GPI_G0CT, 32'h1);
    wr(`GPI_G1E0, 32'hc0);
    wr(`GPI_G1P0, 32'h40);
    wr(`GPI_G1CT, 32'h3);
    pwr_mode <= `GPI_PM_PDN;
    ext[5] <= 1'b1;
    ext[6] <= 1'b1;
    cyc(6);
    #1 chk(64'h3, {62'h0, grp_irq});
    chk(64'h1, {63'h0, wake_req});
    pwr_mode <= `GPI_PM_ACT;
    ext[7] <= 1'b1;
    wr(`GPI_G0CT, 32'h1);
    wr(`GPI_G1CT, 32'h3);
    cyc(4);
    #1 chk(64'h0, {62'h0, grp_irq});
    rdc(`GPI_G0CT, 32'h4);
    rdc(`GPI_G1CT, 32'h2);
    $display("group test done");
    conclude();
  end
endmodule
`default_nettype wire
